// ---- src/mahr_regs.sv ----
// MAC station address, multicast hash and PHY management register bank
//
// What this block does
// - Address-high holds bits 15:0 in low half
// - Boot load address-high from bytes five, six
// - Address-low loaded from bytes one to four
// - Address-low byte 0 is first on wire
// - Leftmost address byte is most significant, first
// - Address ignores host writes until boot load completes
// - Six-bit hash index: top bit picks word
// - Index 0 is low bit 0; 63 high bit 31
// - Accept group frame when selected bit set
// - Pass-all bit accepts every group frame
// - Two fully read-write 32-bit hash words
// - Bits 10:6 select the PHY register
// - Bit 1 set writes, clear reads PHY
// - Busy held during access, cleared on completion
// - Read data valid once busy clears
// - Data register carries 16-bit PHY value
`timescale 1ns/1ps

module mahr_regs
    import mahr_pkg::*;
#(
    parameter int HashBits = 6
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_b,
    // Wishbone slave
    input  wire mahr_pkg::mahr_wbreq_type wbReq,
    output      mahr_pkg::mahr_wbrsp_type wbRsp,
    // Configuration memory loader
    input  wire logic                 romPresent,
    input  wire logic                 romReady,
    output      logic                 romRdReq,
    output      logic [2:0]           romLoc,
    input  wire logic                 romValid,
    input  wire logic [7:0]           romByte,
    output      logic                 initDone,
    // Receive filter
    input  wire logic                 rxGroupValid,
    input  wire logic [HashBits-1:0]  rxHashIndex,
    output      logic                 rxGroupAccept,
    output      logic [47:0]          stationAddr,
    // PHY management pins
    output      mahr_pkg::mahr_mdio_type mdioPins,
    input  wire logic                 mdioIn
);
    import mahr_pkg::*;

    localparam logic [6:0] DivMax = 7'(MdcHalfCyc - 1);

    logic [31:0]   addrHigh_q, addrHigh_d;
    logic [31:0]   addrLow_q, addrLow_d;
    logic [31:0]   hashUp_q, hashUp_d;
    logic [31:0]   hashLo_q, hashLo_d;
    logic [31:0]   phyAcc_q, phyAcc_d;
    logic [15:0]   phyData_q, phyData_d;
    logic          mcPass_q, mcPass_d;
    logic          ack_q, ack_d;
    logic [31:0]   rdat_q, rdat_d;
    mahr_load_type ld_q, ld_d;
    logic [2:0]    loc_q, loc_d;
    mahr_mgmt_type mg_q, mg_d;
    logic [6:0]    div_q, div_d;
    logic          mdc_q, mdc_d;
    logic [6:0]    bit_q, bit_d;
    logic [63:0]   sh_q, sh_d;
    logic          accept_q, accept_d;
    logic          wr;
    logic          rd;
    logic [31:0]   wmask;
    logic          mdcRise;
    logic          mdcFall;
    logic          sampleBit;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wbReq.sel[i]}};
        end
    end

    assign wr = wbReq.cyc && wbReq.stb && wbReq.we && !ack_q;
    assign rd = wbReq.cyc && wbReq.stb && !wbReq.we && !ack_q;

    // Management clock divider: one-cycle enables on each edge of mdc
    assign mdcRise = (mg_q == MgShift) && (div_q == DivMax) && !mdc_q;
    assign mdcFall = (mg_q == MgShift) && (div_q == DivMax) && mdc_q;
    // Read data bits follow the turnaround, sampled on the rising edge
    assign sampleBit = mdcRise && !phyAcc_q[DirBit] && (bit_q >= 7'd48);

    // Registers, loader and bus answer
    always_comb begin
        addrHigh_d = addrHigh_q;
        addrLow_d  = addrLow_q;
        hashUp_d   = hashUp_q;
        hashLo_d   = hashLo_q;
        phyAcc_d   = phyAcc_q;
        phyData_d  = phyData_q;
        mcPass_d   = mcPass_q;
        ld_d       = ld_q;
        loc_d      = loc_q;
        ack_d      = (wr || rd);
        rdat_d     = rdat_q;
        case (ld_q)
            LdWait: begin
                if (romReady) begin
                    ld_d = romPresent ? LdReq : LdDone;
                end
            end
            LdReq: begin
                if (romValid) begin
                    // Byte k lands in wire order slot k
                    case (loc_q)
                        3'h1: addrLow_d[7:0]    = romByte;
                        3'h2: addrLow_d[15:8]   = romByte;
                        3'h3: addrLow_d[23:16]  = romByte;
                        3'h4: addrLow_d[31:24]  = romByte;
                        3'h5: addrHigh_d[7:0]   = romByte;
                        3'h6: addrHigh_d[15:8]  = romByte;
                        default: addrLow_d      = addrLow_q;
                    endcase
                    loc_d = loc_q + 3'h1;
                    if (loc_q == RomLastLoc) begin
                        ld_d = LdDone;
                    end
                end
            end
            LdDone: ld_d = LdDone;
            default: ld_d = LdWait;
        endcase
        // Host writes to the address are dropped until boot load is over
        if (wr) begin
            case (wbReq.adr)
                IdxAddrHigh: if (ld_q == LdDone) begin
                    addrHigh_d = ((addrHigh_q & ~wmask) | (wbReq.dat & wmask))
                               & 32'h0000ffff;
                end
                IdxAddrLow: if (ld_q == LdDone) begin
                    addrLow_d = (addrLow_q & ~wmask) | (wbReq.dat & wmask);
                end
                IdxHashUpper: hashUp_d = (hashUp_q & ~wmask)
                                       | (wbReq.dat & wmask);
                IdxHashLower: hashLo_d = (hashLo_q & ~wmask)
                                       | (wbReq.dat & wmask);
                IdxPhyAccess: if (!phyAcc_q[BusyBit]) begin
                    // Writes while busy are dropped to protect the frame
                    phyAcc_d = ((phyAcc_q & ~wmask) | (wbReq.dat & wmask))
                             & 32'h0000ffc3;
                end
                IdxPhyData: if (!phyAcc_q[BusyBit]) begin
                    phyData_d = (phyData_q & ~wmask[15:0])
                              | (wbReq.dat[15:0] & wmask[15:0]);
                end
                IdxControl: if (wbReq.sel[0]) begin
                    mcPass_d = wbReq.dat[McPassBit];
                end
                default: mcPass_d = mcPass_q;
            endcase
        end
        if (sampleBit) begin
            phyData_d = {phyData_q[14:0], mdioIn};
        end
        if (mg_q == MgDone) begin
            phyAcc_d[BusyBit] = 1'b0;
        end
        if (rd) begin
            case (wbReq.adr)
                IdxAddrHigh:  rdat_d = addrHigh_q;
                IdxAddrLow:   rdat_d = addrLow_q;
                IdxHashUpper: rdat_d = hashUp_q;
                IdxHashLower: rdat_d = hashLo_q;
                IdxPhyAccess: rdat_d = phyAcc_q;
                IdxPhyData:   rdat_d = {16'h0000, phyData_q};
                IdxControl:   rdat_d = {31'h0, mcPass_q};
                default:      rdat_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            addrHigh_q <= RstAddrHigh;
            addrLow_q  <= RstAddrLow;
            hashUp_q   <= RstHash;
            hashLo_q   <= RstHash;
            phyAcc_q   <= RstPhyAccess;
            phyData_q  <= 16'h0000;
            mcPass_q   <= 1'b0;
            ld_q       <= LdWait;
            loc_q      <= RomFirstLoc;
            ack_q      <= 1'b0;
            rdat_q     <= 32'h00000000;
        end else begin
            addrHigh_q <= addrHigh_d;
            addrLow_q  <= addrLow_d;
            hashUp_q   <= hashUp_d;
            hashLo_q   <= hashLo_d;
            phyAcc_q   <= phyAcc_d;
            phyData_q  <= phyData_d;
            mcPass_q   <= mcPass_d;
            ld_q       <= ld_d;
            loc_q      <= loc_d;
            ack_q      <= ack_d;
            rdat_q     <= rdat_d;
        end
    end

    // Management frame engine
    always_comb begin
        mg_d  = mg_q;
        div_d = div_q;
        mdc_d = mdc_q;
        bit_d = bit_q;
        sh_d  = sh_q;
        case (mg_q)
            MgIdle: begin
                div_d = 7'h00;
                mdc_d = 1'b0;
                bit_d = 7'h00;
                if (phyAcc_q[BusyBit]) begin
                    // Preamble, start, opcode, addresses, turnaround, data
                    sh_d = {32'hffffffff, 2'b01,
                            phyAcc_q[DirBit] ? 2'b01 : 2'b10,
                            phyAcc_q[15:11], phyAcc_q[10:6],
                            2'b10, phyData_q};
                    mg_d = MgShift;
                end
            end
            MgShift: begin
                div_d = (div_q == DivMax) ? 7'h00 : div_q + 7'h01;
                if (mdcRise) begin
                    mdc_d = 1'b1;
                end
                if (mdcFall) begin
                    mdc_d = 1'b0;
                    sh_d  = {sh_q[62:0], 1'b1};
                    bit_d = bit_q + 7'h01;
                    if (bit_q == 7'(FrameBits - 1)) begin
                        mg_d = MgDone;
                    end
                end
            end
            MgDone: mg_d = MgIdle;
            default: mg_d = MgIdle;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mg_q  <= MgIdle;
            div_q <= 7'h00;
            mdc_q <= 1'b0;
            bit_q <= 7'h00;
            sh_q  <= 64'h0;
        end else begin
            mg_q  <= mg_d;
            div_q <= div_d;
            mdc_q <= mdc_d;
            bit_q <= bit_d;
            sh_q  <= sh_d;
        end
    end

    // Group address filter
    always_comb begin
        accept_d = accept_q;
        if (rxGroupValid) begin
            accept_d = mcPass_q
                || (rxHashIndex[5] ? hashUp_q[rxHashIndex[4:0]]
                                   : hashLo_q[rxHashIndex[4:0]]);
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            accept_q <= 1'b0;
        end else begin
            accept_q <= accept_d;
        end
    end

    // Wire order: byte 0 of address-low is first, most significant
    assign stationAddr   = {addrLow_q[7:0], addrLow_q[15:8], addrLow_q[23:16],
                            addrLow_q[31:24], addrHigh_q[7:0],
                            addrHigh_q[15:8]};
    assign rxGroupAccept = accept_q;
    assign initDone      = (ld_q == LdDone);
    assign romRdReq      = (ld_q == LdReq);
    assign romLoc        = loc_q;
    assign wbRsp.ack     = ack_q;
    assign wbRsp.dat     = rdat_q;
    // Pin released (enable high) during turnaround and data of a read
    assign mdioPins.mdc      = mdc_q;
    assign mdioPins.mdioOut  = sh_q[63];
    assign mdioPins.mdioOe_n = (mg_q != MgShift)
                             || (!phyAcc_q[DirBit] && bit_q >= 7'd46);

endmodule : mahr_regs

// ---- src/mahr_pkg.sv ----
// Register map, field layout and timing constants for the MAC address bank
package mahr_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [3:0] IdxAddrHigh  = 4'h2;
    localparam logic [3:0] IdxAddrLow   = 4'h3;
    localparam logic [3:0] IdxHashUpper = 4'h4;
    localparam logic [3:0] IdxHashLower = 4'h5;
    localparam logic [3:0] IdxPhyAccess = 4'h6;
    localparam logic [3:0] IdxPhyData   = 4'h7;
    localparam logic [3:0] IdxControl   = 4'h8;

    // Reset values
    localparam logic [31:0] RstAddrHigh  = 32'h0000ffff;
    localparam logic [31:0] RstAddrLow   = 32'h0fffffff;
    localparam logic [31:0] RstHash      = 32'h00000000;
    localparam logic [31:0] RstPhyAccess = 32'h00000000;

    // Access register field positions
    localparam int PhyAddrLsb = 11;
    localparam int PhyRegLsb  = 6;
    localparam int DirBit     = 1;
    localparam int BusyBit    = 0;
    localparam int McPassBit  = 0;

    // Management clock: 100 MHz over 40 gives 2.5 MHz
    localparam int ClkMhz       = 100;
    localparam int MdcPeriodNs  = 400;
    localparam int MdcHalfCyc   = (MdcPeriodNs * ClkMhz) / 2000;
    localparam int FrameBits    = 64;

    // Configuration byte locations for the station address
    localparam logic [2:0] RomFirstLoc = 3'h1;
    localparam logic [2:0] RomLastLoc  = 3'h6;

    typedef enum logic [2:0] {
        MgIdle  = 3'b000,
        MgShift = 3'b001,
        MgDone  = 3'b011
    } mahr_mgmt_type;

    typedef enum logic [1:0] {
        LdWait = 2'b00,
        LdReq  = 2'b01,
        LdDone = 2'b11
    } mahr_load_type;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [5:2]  adr;
        logic [31:0] dat;
    } mahr_wbreq_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } mahr_wbrsp_type;

    typedef struct packed {
        logic       mdc;
        logic       mdioOut;
        logic       mdioOe_n;
    } mahr_mdio_type;

endpackage : mahr_pkg

// ---- dv/mahr_regs_props.sv ----
// Port-level checks for the MAC address bank
`timescale 1ns/1ps
module mahr_regs_props
    import mahr_pkg::*;
#(
    parameter int HashBits = 6
) (
    // Clock and reset
    input wire logic                    mclk,
    input wire logic                    rst_b,
    // Watched ports
    input wire mahr_pkg::mahr_wbreq_type wbReq,
    input wire mahr_pkg::mahr_wbrsp_type wbRsp,
    input wire logic                    romRdReq,
    input wire logic [2:0]              romLoc,
    input wire logic                    romValid,
    input wire logic [7:0]              romByte,
    input wire logic                    initDone,
    input wire logic                    rxGroupValid,
    input wire logic                    rxGroupAccept,
    input wire logic [47:0]             stationAddr,
    input wire mahr_pkg::mahr_mdio_type mdioPins
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic       mdcQ;
    logic [5:0] run_q;
    logic [5:0] run_d;
    // Saturates; a rise is checked only when short, since the idle gap
    // before a frame also ends in a rise and is never under 22 cycles
    always_comb begin
        run_d = (mdioPins.mdc != mdcQ) ? 6'h00
              : run_q + {5'h00, run_q != 6'h3f};
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mdcQ  <= 1'b0;
            run_q <= 6'h3f;
        end else begin
            mdcQ  <= mdioPins.mdc;
            run_q <= run_d;
        end
    end
    sequence wbTaken;
        wbReq.cyc && wbReq.stb && !wbRsp.ack;
    endsequence
    sequence romStep;
        romRdReq && romValid;
    endsequence
    ack_after_req_a: assert property (wbTaken |=> wbRsp.ack)
        else $error("ack missing after request");
    ack_single_a: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack longer than one cycle");
    unmapped_zero_a: assert property (wbRsp.ack && !$past(wbReq.we)
        && $past(wbReq.adr) == 4'hf |-> wbRsp.dat == 32'h0)
        else $error("unmapped read not zero");
    rom_step_a: assert property (romStep ##0 (romLoc != 3'h6) |=>
        romLoc == $past(romLoc) + 3'h1) else $error("byte location skip");
    rom_range_a: assert property (romRdReq |->
        romLoc inside {[3'h1:3'h6]}) else $error("byte location range");
    first_byte_a: assert property (romStep ##0 (romLoc == 3'h1) |=>
        stationAddr[47:40] == $past(romByte)) else $error("first byte");
    last_byte_a: assert property (romStep ##0 (romLoc == 3'h6) |=>
        stationAddr[7:0] == $past(romByte)) else $error("last byte");
    init_hold_a: assert property (initDone |=> initDone && !romRdReq)
        else $error("load restarted");
    accept_hold_a: assert property (!rxGroupValid |=>
        $stable(rxGroupAccept)) else $error("accept moved");
    mdc_half_a: assert property (mdioPins.mdc != mdcQ
        && (mdcQ || run_q < 6'd21) |-> run_q == MdcHalfCyc - 1)
        else $error("mdc half period");
endmodule : mahr_regs_props
bind mahr_regs mahr_regs_props #(.HashBits(HashBits)) u_props (
    .mclk(mclk), .rst_b(rst_b), .wbReq(wbReq), .wbRsp(wbRsp),
    .romRdReq(romRdReq), .romLoc(romLoc), .romValid(romValid),
    .romByte(romByte), .initDone(initDone), .rxGroupValid(rxGroupValid),
    .rxGroupAccept(rxGroupAccept), .stationAddr(stationAddr),
    .mdioPins(mdioPins));

// ---- dv/mahr_phy_model.sv ----
// Behavioural config memory and PHY management partner
`timescale 1ns/1ps
module mahr_phy_model
    import mahr_pkg::*;
#(
    parameter int          RomLat  = 3,
    parameter logic [15:0] ReadVal = 16'h3e5b
) (
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    // Config memory
    input  wire logic                    romRdReq,
    input  wire logic [2:0]              romLoc,
    output      logic                    romValid,
    output      logic [7:0]              romByte,
    // Management line
    input  wire mahr_pkg::mahr_mdio_type mdioPins,
    output      logic                    mdioIn,
    output      logic [63:0]             frame
);
    logic [3:0]  dly_q, dly_d;
    logic        valid_q, valid_d, isRd_q, isRd_d, mdcPrev_q, rise, pin;
    logic [5:0]  cnt_q, cnt_d;
    logic [63:0] frame_q, frame_d;
    assign rise = mdioPins.mdc && !mdcPrev_q;
    // Pulled-up line; PHY drives only turnaround low and the read data
    assign pin = !mdioPins.mdioOe_n ? mdioPins.mdioOut
               : !(isRd_q && cnt_q >= 6'd47) ? 1'b1
               : (cnt_q == 6'd47) ? 1'b0 : ReadVal[6'd63 - cnt_q];
    assign mdioIn   = pin;
    assign frame    = frame_q;
    assign romValid = valid_q;
    // Byte k of the memory is 0k0k; outside a pulse the bus shows garbage
    assign romByte  = valid_q ? {1'b0, romLoc, 1'b0, romLoc}
                              : ~{1'b0, romLoc, 1'b0, romLoc};
    always_comb begin
        dly_d   = (romRdReq && !valid_q) ? dly_q + 4'h1 : 4'h0;
        valid_d = romRdReq && !valid_q && dly_q == 4'(RomLat);
        cnt_d   = rise ? cnt_q + 6'h01 : cnt_q;
        frame_d = rise ? {frame_q[62:0], pin} : frame_q;
        isRd_d  = isRd_q;
        if (rise && cnt_q == 6'd35) begin
            isRd_d = {frame_q[0], pin} == 2'b10;
        end
        if (rise && cnt_q == 6'd63) begin
            isRd_d = 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dly_q     <= 4'h0;
            valid_q   <= 1'b0;
            isRd_q    <= 1'b0;
            mdcPrev_q <= 1'b0;
            cnt_q     <= 6'h00;
            frame_q   <= 64'h0;
        end else begin
            dly_q     <= dly_d;
            valid_q   <= valid_d;
            isRd_q    <= isRd_d;
            mdcPrev_q <= mdioPins.mdc;
            cnt_q     <= cnt_d;
            frame_q   <= frame_d;
        end
    end
endmodule : mahr_phy_model

// ---- dv/mahr_regs_bench.sv ----
// Self-checking bench for the MAC address bank
`timescale 1ns/1ps
module mahr_regs_bench;
    import mahr_pkg::*;
    localparam logic [15:0] RdVal = 16'h3e5b;
    logic           mclk = 1'b0, rst_b = 1'b0, romPresent = 1'b1;
    logic           romReady = 1'b0, rxGroupValid = 1'b0;
    logic [5:0]     rxHashIndex = 6'h00;
    logic           romRdReq, romValid, initDone, rxGroupAccept, mdioIn;
    logic [2:0]     romLoc;
    logic [7:0]     romByte;
    logic [47:0]    stationAddr;
    logic [63:0]    frame;
    mahr_wbreq_type wbReq = '0;
    mahr_wbrsp_type wbRsp;
    mahr_mdio_type  mdioPins;
    int             errors = 0, n_tests = 0;
    always #5 mclk = ~mclk;
    mahr_regs u_mahr_regs (.mclk(mclk), .rst_b(rst_b), .wbReq(wbReq),
        .wbRsp(wbRsp), .romPresent(romPresent), .romReady(romReady),
        .romRdReq(romRdReq), .romLoc(romLoc), .romValid(romValid),
        .romByte(romByte), .initDone(initDone), .rxGroupValid(rxGroupValid),
        .rxHashIndex(rxHashIndex), .rxGroupAccept(rxGroupAccept),
        .stationAddr(stationAddr), .mdioPins(mdioPins), .mdioIn(mdioIn));
    mahr_phy_model #(.ReadVal(RdVal)) u_mahr_phy_model (.mclk(mclk),
        .rst_b(rst_b), .romRdReq(romRdReq), .romLoc(romLoc),
        .romValid(romValid), .romByte(romByte), .mdioPins(mdioPins),
        .mdioIn(mdioIn), .frame(frame));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [63:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [3:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
        int k;
        @(posedge mclk);
        wbReq <= '{1'b1, 1'b1, we, 4'hf, idx, wd};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (wbRsp.ack !== 1'b1 && k < 20);
        rd = wbRsp.dat;
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
        if (wbRsp.ack !== 1'b1) begin
            chk("bus ack", 64'h1, 64'h0);
            end_of_test();
        end
    endtask : wb
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        logic [31:0] v;
        wb(1'b1, idx, d, v);
    endtask : wr
    task automatic rdc(input logic [3:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        wb(1'b0, idx, 32'h0, v);
        chk($sformatf("register %0d", idx), {32'h0, exp}, {32'h0, v});
    endtask : rdc
    task automatic waitIdle();
        logic [31:0] v;
        int k;
        v = 32'h1;
        for (k = 0; k < 1500 && v[BusyBit] !== 1'b0; k++) begin
            wb(1'b0, IdxPhyAccess, 32'h0, v);
        end
        chk("busy clear", 64'h0, {63'h0, v[BusyBit]});
    endtask : waitIdle
    task automatic sweep(input logic pass, input logic [63:0] tbl);
        int i;
        for (i = 0; i < 64; i++) begin
            @(posedge mclk);
            rxGroupValid <= 1'b1;
            rxHashIndex  <= 6'(i);
            @(posedge mclk);
            rxGroupValid <= 1'b0;
            @(posedge mclk);
            chk("accept", {63'h0, pass | tbl[i]}, {63'h0, rxGroupAccept});
        end
    endtask : sweep
    initial begin
        int k;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        rdc(IdxAddrHigh, RstAddrHigh);
        rdc(IdxAddrLow, RstAddrLow);
        rdc(IdxHashUpper, RstHash);
        rdc(IdxPhyAccess, RstPhyAccess);
        wr(IdxAddrLow, 32'h0);
        rdc(IdxAddrLow, RstAddrLow);
        rdc(4'hf, 32'h0);
        $display("test reset values done");
        romReady <= 1'b1;
        for (k = 0; k < 200 && initDone !== 1'b1; k++) @(posedge mclk);
        chk("load done", 64'h1, {63'h0, initDone});
        rdc(IdxAddrLow, 32'h44332211);
        rdc(IdxAddrHigh, 32'h00006655);
        chk("station", 64'h112233445566, {16'h0, stationAddr});
        wr(IdxAddrHigh, 32'hffffffff);
        wr(IdxAddrLow, 32'h12345678);
        rdc(IdxAddrHigh, 32'h0000ffff);
        chk("station", 64'h78563412ffff, {16'h0, stationAddr});
        $display("test station address done");
        wr(IdxHashUpper, 32'h8c3f5a96);
        wr(IdxHashLower, 32'ha5a50f01);
        rdc(IdxHashUpper, 32'h8c3f5a96);
        rdc(IdxHashLower, 32'ha5a50f01);
        sweep(1'b0, 64'h8c3f5a96a5a50f01);
        wr(IdxControl, 32'h1);
        sweep(1'b1, 64'h8c3f5a96a5a50f01);
        $display("test hash filter done");
        wr(IdxPhyData, 32'h0000a5c3);
        wr(IdxPhyAccess, 32'h00000a83);
        wr(IdxPhyData, 32'h0000ffff);
        rdc(IdxPhyAccess, 32'h00000a83);
        waitIdle();
        chk("write frame", {32'hffffffff, 4'b0101, 5'h01, 5'h0a, 2'b10,
            16'ha5c3}, frame);
        rdc(IdxPhyAccess, 32'h00000a82);
        rdc(IdxPhyData, 32'h0000a5c3);
        wr(IdxPhyAccess, 32'h00000cc1);
        waitIdle();
        chk("read frame", {32'hffffffff, 4'b0110, 5'h01, 5'h13, 2'b10,
            RdVal}, frame);
        rdc(IdxPhyData, {16'h0, RdVal});
        $display("test phy management done");
        rst_b      <= 1'b0;
        romPresent <= 1'b0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        for (k = 0; k < 200 && initDone !== 1'b1; k++) @(posedge mclk);
        chk("load skipped", 64'h1, {63'h0, initDone});
        rdc(IdxAddrLow, RstAddrLow);
        chk("station", 64'hffffff0fffff, {16'h0, stationAddr});
        wr(IdxAddrHigh, 32'h00001234);
        rdc(IdxAddrHigh, 32'h00001234);
        $display("test absent memory done");
        end_of_test();
    end
endmodule : mahr_regs_bench
